// >>> rtl/aps_defines.svh
// constants for the auxiliary pin selector
`ifndef APS_DEFINES_SVH
`define APS_DEFINES_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define APS_NUM_PINS 5
`define APS_NUM_IO_PINS 4
`define APS_CODE_W 4
`define APS_CFG_W 20
`define APS_DIV_W 4
`define APS_LED_CNT_W 21
`define APS_NUM_LEDS 3

// ----------------------------------------------------------------
// role codes as written into the stored setting
// ----------------------------------------------------------------
`define APS_CODE_LINE_DRV 4'h0
`define APS_CODE_POWER 4'h1
`define APS_CODE_TX_LED 4'h2
`define APS_CODE_RX_LED 4'h3
`define APS_CODE_ANY_LED 4'h4
`define APS_CODE_SLEEP 4'h5
`define APS_CODE_CLK_FASTEST 4'h6
`define APS_CODE_CLK_HALF 4'h7
`define APS_CODE_CLK_QUARTER 4'h8
`define APS_CODE_CLK_EIGHTH 4'h9
`define APS_CODE_GENERAL_IO 4'ha
`define APS_CODE_WR_STROBE 4'hb
`define APS_CODE_RD_STROBE 4'hc
`define APS_CODE_IDLE 4'hf

// power-up setting: pin4 sleep, pin3 power, pin2 line driver,
// pin1 rx led, pin0 tx led
`define APS_CFG_RESET 20'h5_1032
`define APS_PULLDOWN_RESET 1'b0

// ----------------------------------------------------------------
// divided clock taps (bit of the divider counter)
// ----------------------------------------------------------------
`define APS_TAP_FASTEST 0
`define APS_TAP_HALF 1
`define APS_TAP_QUARTER 2
`define APS_TAP_EIGHTH 3
`define APS_DIV_ZERO 4'h0
`define APS_DIV_STEP 4'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define APS_CLK_KHZ 25000
`define APS_LED_HOLD_MS 50
`define APS_LED_CNT_ZERO 21'h00_0000
`define APS_LED_CNT_STEP 21'h00_0001

// led channel order inside the stretcher
`define APS_LED_TX 0
`define APS_LED_RX 1
`define APS_LED_ANY 2

`endif

// >>> rtl/aps_pkg.sv
// types shared by the auxiliary pin selector
package aps_pkg;

  typedef enum logic [3:0] {
    APS_ROLE_LINE_DRV,
    APS_ROLE_POWER,
    APS_ROLE_TX_LED,
    APS_ROLE_RX_LED,
    APS_ROLE_ANY_LED,
    APS_ROLE_SLEEP,
    APS_ROLE_CLK_FASTEST,
    APS_ROLE_CLK_HALF,
    APS_ROLE_CLK_QUARTER,
    APS_ROLE_CLK_EIGHTH,
    APS_ROLE_GENERAL_IO,
    APS_ROLE_WR_STROBE,
    APS_ROLE_RD_STROBE,
    APS_ROLE_IDLE
  } aps_role_e;

endpackage

// >>> rtl/aps_act_if.sv
// activity-to-led carrier between the selector and the stretcher
`timescale 1ns/1ns
`default_nettype none
`include "aps_defines.svh"

interface aps_act_if;
  logic tx_act;
  logic rx_act;
  logic [`APS_NUM_LEDS-1:0] led_n;

  modport src (output tx_act, output rx_act, input led_n);
  modport stretch (input tx_act, input rx_act, output led_n);
endinterface

`default_nettype wire

// >>> rtl/aps_led_stretch.sv
// activity led pulse stretcher, three channels
`timescale 1ns/1ns
`default_nettype none
`include "aps_defines.svh"

module aps_led_stretch #(
  parameter int unsigned HOLD_CYC = `APS_LED_HOLD_MS * `APS_CLK_KHZ
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // activity in, led drive out
  aps_act_if.stretch act
);

  logic [`APS_NUM_LEDS-1:0] act_w;
  localparam logic [`APS_LED_CNT_W-1:0] HOLD_W =
    HOLD_CYC[`APS_LED_CNT_W-1:0];

  assign act_w[`APS_LED_TX] = act.tx_act;
  assign act_w[`APS_LED_RX] = act.rx_act;
  assign act_w[`APS_LED_ANY] = act.tx_act | act.rx_act;

  genvar g;
  generate
    for (g = 0; g < `APS_NUM_LEDS; g++) begin : g_led
      logic [`APS_LED_CNT_W-1:0] cnt_ff;
      logic [`APS_LED_CNT_W-1:0] nxt_cnt;
      logic led_n_ff;
      logic nxt_led_n;

      // ----------------------------------------------------------
      // stretch
      // ----------------------------------------------------------
      // each burst reloads the hold, so steady traffic keeps the
      // led lit instead of flickering at byte rate
      always_comb begin
        nxt_cnt = cnt_ff;
        if (act_w[g]) begin
          nxt_cnt = HOLD_W; // [RULE_14]
        end else if (cnt_ff != `APS_LED_CNT_ZERO) begin
          nxt_cnt = cnt_ff - `APS_LED_CNT_STEP;
        end
        nxt_led_n = !(act_w[g] || (nxt_cnt != `APS_LED_CNT_ZERO));
      end

      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          cnt_ff <= `APS_LED_CNT_ZERO;
          led_n_ff <= 1'b1;
        end else begin
          cnt_ff <= nxt_cnt;
          led_n_ff <= nxt_led_n;
        end
      end

      assign act.led_n[g] = led_n_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// >>> rtl/aps_pin_selector.sv
// auxiliary pin function selector, top level
`timescale 1ns/1ns
`default_nettype none
`include "aps_defines.svh"

// Overview of operation
// RULE_01 - pin roles come from stored, host-written setting
// RULE_02 - line driver enable active while uart sends
// RULE_03 - power enable low configured, high in suspend
// RULE_04 - power role should enable soft pull-down
// RULE_05 - tx led pulses low on usb transmit
// RULE_06 - rx led pulses low on receive
// RULE_07 - combined led pulses low on either
// RULE_08 - sleep pin low throughout usb suspend
// RULE_09 - divided clocks free-run, stop in suspend
// RULE_10 - io and strobe roles only pins 0-3
// RULE_11 - each lower pin individually general io
// RULE_12 - write strobe role outputs bit-bang write strobe
// RULE_13 - read strobe role outputs bit-bang read strobe
// RULE_14 - led pulses stretched to build-time minimum
module aps_pin_selector
  import aps_pkg::*;
#(
  parameter int unsigned LED_HOLD_CYC = `APS_LED_HOLD_MS * `APS_CLK_KHZ
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // stored setting, written by host software
  input wire logic cfg_wr_in,
  input wire logic [`APS_CFG_W-1:0] cfg_roles_in,
  input wire logic cfg_pulldown_in,
  // usb engine and uart state
  input wire logic usb_configured_in,
  input wire logic usb_suspend_in,
  input wire logic usb_tx_act_in,
  input wire logic usb_rx_act_in,
  input wire logic uart_tx_busy_in,
  // bit-bang engine
  input wire logic [`APS_NUM_IO_PINS-1:0] gpio_drive_in,
  input wire logic [`APS_NUM_IO_PINS-1:0] gpio_oe_in,
  input wire logic parallel_write_strobe_n_in,
  input wire logic parallel_read_strobe_n_in,
  output logic [`APS_NUM_IO_PINS-1:0] gpio_sample_out,
  // pins
  input wire logic [`APS_NUM_IO_PINS-1:0] aux_pin_in,
  output logic [`APS_NUM_PINS-1:0] aux_pin_out,
  output logic [`APS_NUM_PINS-1:0] aux_pin_oe_out,
  // status
  output logic [`APS_CFG_W-1:0] cfg_roles_out,
  output logic soft_pulldown_en_out
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // pin index decides legality: the top pin is output only, so io
  // and strobe codes fall back to idle there
  function automatic aps_role_e role_of(input logic [3:0] code,
                                        input int pin);
    aps_role_e r;
    r = APS_ROLE_IDLE;
    if (code == `APS_CODE_LINE_DRV) begin
      r = APS_ROLE_LINE_DRV;
    end else if (code == `APS_CODE_POWER) begin
      r = APS_ROLE_POWER;
    end else if (code == `APS_CODE_TX_LED) begin
      r = APS_ROLE_TX_LED;
    end else if (code == `APS_CODE_RX_LED) begin
      r = APS_ROLE_RX_LED;
    end else if (code == `APS_CODE_ANY_LED) begin
      r = APS_ROLE_ANY_LED;
    end else if (code == `APS_CODE_SLEEP) begin
      r = APS_ROLE_SLEEP;
    end else if (code == `APS_CODE_CLK_FASTEST) begin
      r = APS_ROLE_CLK_FASTEST;
    end else if (code == `APS_CODE_CLK_HALF) begin
      r = APS_ROLE_CLK_HALF;
    end else if (code == `APS_CODE_CLK_QUARTER) begin
      r = APS_ROLE_CLK_QUARTER;
    end else if (code == `APS_CODE_CLK_EIGHTH) begin
      r = APS_ROLE_CLK_EIGHTH;
    end else if (pin < `APS_NUM_IO_PINS) begin // [RULE_10]
      if (code == `APS_CODE_GENERAL_IO) begin
        r = APS_ROLE_GENERAL_IO;
      end else if (code == `APS_CODE_WR_STROBE) begin
        r = APS_ROLE_WR_STROBE;
      end else if (code == `APS_CODE_RD_STROBE) begin
        r = APS_ROLE_RD_STROBE;
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] code_of(input aps_role_e r);
    logic [3:0] c;
    c = `APS_CODE_IDLE;
    case (r)
      APS_ROLE_LINE_DRV: c = `APS_CODE_LINE_DRV;
      APS_ROLE_POWER: c = `APS_CODE_POWER;
      APS_ROLE_TX_LED: c = `APS_CODE_TX_LED;
      APS_ROLE_RX_LED: c = `APS_CODE_RX_LED;
      APS_ROLE_ANY_LED: c = `APS_CODE_ANY_LED;
      APS_ROLE_SLEEP: c = `APS_CODE_SLEEP;
      APS_ROLE_CLK_FASTEST: c = `APS_CODE_CLK_FASTEST;
      APS_ROLE_CLK_HALF: c = `APS_CODE_CLK_HALF;
      APS_ROLE_CLK_QUARTER: c = `APS_CODE_CLK_QUARTER;
      APS_ROLE_CLK_EIGHTH: c = `APS_CODE_CLK_EIGHTH;
      APS_ROLE_GENERAL_IO: c = `APS_CODE_GENERAL_IO;
      APS_ROLE_WR_STROBE: c = `APS_CODE_WR_STROBE;
      APS_ROLE_RD_STROBE: c = `APS_CODE_RD_STROBE;
      default: c = `APS_CODE_IDLE;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  aps_role_e role_ff [`APS_NUM_PINS];
  aps_role_e nxt_role [`APS_NUM_PINS];
  logic pulldown_ff;
  logic nxt_pulldown;
  logic [`APS_DIV_W-1:0] div_ff;
  logic [`APS_DIV_W-1:0] nxt_div;
  logic [`APS_NUM_PINS-1:0] pin_ff;
  logic [`APS_NUM_PINS-1:0] nxt_pin;
  logic [`APS_NUM_PINS-1:0] oe_ff;
  logic [`APS_NUM_PINS-1:0] nxt_oe;
  logic [`APS_NUM_IO_PINS-1:0] gpio_in_ff;
  logic [`APS_CFG_W-1:0] roles_code_ff;
  logic [`APS_CFG_W-1:0] nxt_roles_code;
  logic power_n;
  logic any_power;
  // reset setting as a sized word so each pin takes its own nibble
  localparam logic [`APS_CFG_W-1:0] CFG_RESET_W = `APS_CFG_RESET;

  aps_act_if act ();

  assign act.tx_act = usb_tx_act_in;
  assign act.rx_act = usb_rx_act_in;

  aps_led_stretch #(
    .HOLD_CYC(LED_HOLD_CYC)
  ) u_led (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .act(act)
  );

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    // the setting lives outside in non-volatile storage; this copy is
    // refreshed whenever the host or loader writes it
    for (int i = 0; i < `APS_NUM_PINS; i++) begin
      nxt_role[i] = role_ff[i];
      if (cfg_wr_in) begin
        nxt_role[i] = role_of(cfg_roles_in[i*4 +: 4], i); // [RULE_01]
      end
      nxt_roles_code[i*4 +: 4] = code_of(nxt_role[i]);
    end
    nxt_pulldown = cfg_wr_in ? cfg_pulldown_in : pulldown_ff;

    // free-running divider, held at zero through suspend
    if (usb_suspend_in) begin
      nxt_div = `APS_DIV_ZERO; // [RULE_09]
    end else begin
      nxt_div = div_ff + `APS_DIV_STEP;
    end

    power_n = !(usb_configured_in && !usb_suspend_in); // [RULE_03]
    any_power = 1'b0;

    for (int i = 0; i < `APS_NUM_PINS; i++) begin
      nxt_oe[i] = 1'b1;
      nxt_pin[i] = 1'b1;
      case (nxt_role[i])
        APS_ROLE_LINE_DRV: nxt_pin[i] = !uart_tx_busy_in; // [RULE_02]
        APS_ROLE_POWER: begin
          nxt_pin[i] = power_n; // [RULE_03]
          any_power = 1'b1;
        end
        APS_ROLE_TX_LED: nxt_pin[i] = act.led_n[`APS_LED_TX]; // [RULE_05]
        APS_ROLE_RX_LED: nxt_pin[i] = act.led_n[`APS_LED_RX]; // [RULE_06]
        APS_ROLE_ANY_LED: nxt_pin[i] = act.led_n[`APS_LED_ANY]; // [RULE_07]
        APS_ROLE_SLEEP: nxt_pin[i] = !usb_suspend_in; // [RULE_08]
        APS_ROLE_CLK_FASTEST: begin
          nxt_pin[i] = div_ff[`APS_TAP_FASTEST]; // [RULE_09]
        end
        APS_ROLE_CLK_HALF: nxt_pin[i] = div_ff[`APS_TAP_HALF]; // [RULE_09]
        APS_ROLE_CLK_QUARTER: begin
          nxt_pin[i] = div_ff[`APS_TAP_QUARTER]; // [RULE_09]
        end
        APS_ROLE_CLK_EIGHTH: nxt_pin[i] = div_ff[`APS_TAP_EIGHTH]; // [RULE_09]
        APS_ROLE_GENERAL_IO: begin
          if (i < `APS_NUM_IO_PINS) begin // [RULE_11]
            nxt_pin[i] = gpio_drive_in[i];
            nxt_oe[i] = gpio_oe_in[i];
          end
        end
        APS_ROLE_WR_STROBE: begin
          nxt_pin[i] = parallel_write_strobe_n_in; // [RULE_12]
        end
        APS_ROLE_RD_STROBE: begin
          nxt_pin[i] = parallel_read_strobe_n_in; // [RULE_13]
        end
        default: nxt_pin[i] = 1'b1;
      endcase
      // a divided clock stops low, not mid-phase, while suspended
      if (usb_suspend_in && nxt_role[i] inside {APS_ROLE_CLK_FASTEST,
          APS_ROLE_CLK_HALF, APS_ROLE_CLK_QUARTER,
          APS_ROLE_CLK_EIGHTH}) begin
        nxt_pin[i] = 1'b0; // [RULE_09]
      end
    end
    // power switch role forces the soft pull-down on so the switched
    // side does not float while its supply is cut
    nxt_pulldown = nxt_pulldown | any_power; // [RULE_04]
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < `APS_NUM_PINS; i++) begin
        role_ff[i] <= role_of(CFG_RESET_W[i*`APS_CODE_W +: `APS_CODE_W], i);
      end
      roles_code_ff <= `APS_CFG_RESET;
      pulldown_ff <= `APS_PULLDOWN_RESET;
      div_ff <= `APS_DIV_ZERO;
      pin_ff <= '1;
      oe_ff <= '1;
      gpio_in_ff <= '0;
    end else begin
      role_ff <= nxt_role;
      roles_code_ff <= nxt_roles_code;
      pulldown_ff <= nxt_pulldown;
      div_ff <= nxt_div;
      pin_ff <= nxt_pin;
      oe_ff <= nxt_oe;
      gpio_in_ff <= aux_pin_in; // [RULE_11]
    end
  end

  assign aux_pin_out = pin_ff;
  assign aux_pin_oe_out = oe_ff;
  assign gpio_sample_out = gpio_in_ff;
  assign cfg_roles_out = roles_code_ff;
  assign soft_pulldown_en_out = pulldown_ff;

endmodule

`default_nettype wire

// >>> sim/aps_far_side.sv
// far-side model: pull-ups and external logic on the lower aux pins
`timescale 1ns/1ns
`default_nettype none
module aps_far_side (
  // pins from the selector
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_oe_in,
  // external logic, used only while the selector lets go of a pin
  input wire logic [3:0] ext_in,
  input wire logic [3:0] ext_en_in,
  // resolved wire levels
  output logic [3:0] level_out
);
  // a released pin with nobody driving floats up to the pull-up
  always_comb begin
    for (int i = 0; i < 4; i++)
      level_out[i] = pin_oe_in[i] ? pin_in[i] :
        (ext_en_in[i] ? ext_in[i] : 1'b1);
  end
endmodule
`default_nettype wire

// >>> sim/aps_pin_monitor.sv
// assertion checker on the auxiliary pin selector ports
`timescale 1ns/1ns
`default_nettype none
`include "aps_defines.svh"
module aps_pin_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // selector inputs
  input wire logic usb_configured_in,
  input wire logic usb_suspend_in,
  input wire logic usb_tx_act_in,
  input wire logic uart_tx_busy_in,
  input wire logic [`APS_NUM_IO_PINS-1:0] gpio_oe_in,
  input wire logic parallel_write_strobe_n_in,
  input wire logic parallel_read_strobe_n_in,
  // selector outputs
  input wire logic [`APS_NUM_PINS-1:0] aux_pin_out,
  input wire logic [`APS_NUM_PINS-1:0] aux_pin_oe_out,
  input wire logic [`APS_CFG_W-1:0] cfg_roles_out
);
  // --------
  // first edge after reset still shows reset values, so skip it
  // --------
  logic live_ff;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      live_ff <= 1'b0;
    else
      live_ff <= 1'b1;
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in || !live_ff);

  pin4_io_a: assert property (
    !(cfg_roles_out[19:16] inside {4'ha, 4'hb, 4'hc}))
    else $error("io role on pin 4");
  for (genvar i = 0; i < `APS_NUM_PINS; i++) begin : g_pin
    wire [3:0] r = cfg_roles_out[4*i +: 4];
    sequence s_tx_seen;
      (r == 4'h2 && usb_tx_act_in) ##1 (r == 4'h2) [*2];
    endsequence
    line_drv_a: assert property (
      r == 4'h0 |-> aux_pin_out[i] == !$past(uart_tx_busy_in))
      else $error("line driver pin wrong");
    power_pin_a: assert property (
      r == 4'h1 |-> aux_pin_out[i] ==
      !($past(usb_configured_in) && !$past(usb_suspend_in)))
      else $error("power pin wrong");
    sleep_pin_a: assert property (
      r == 4'h5 |-> aux_pin_out[i] == !$past(usb_suspend_in))
      else $error("sleep pin wrong");
    clk_stop_a: assert property (
      r inside {[4'h6:4'h9]} && $past(usb_suspend_in) |-> !aux_pin_out[i])
      else $error("clock pin runs in suspend");
    // two awake cycles in a row must flip the fastest clock pin
    clk_run_a: assert property (
      r == 4'h6 && $past(r) == 4'h6 && !$past(usb_suspend_in) &&
      !$past(usb_suspend_in, 2) |-> aux_pin_out[i] != $past(aux_pin_out[i]))
      else $error("fastest clock pin not toggling");
    tx_led_a: assert property (
      s_tx_seen |-> !aux_pin_out[i])
      else $error("tx led not lit");
    if (i < `APS_NUM_IO_PINS) begin : g_io
      wr_strobe_a: assert property (
        r == 4'hb |-> aux_pin_out[i] == $past(parallel_write_strobe_n_in))
        else $error("write strobe pin wrong");
      rd_strobe_a: assert property (
        r == 4'hc |-> aux_pin_out[i] == $past(parallel_read_strobe_n_in))
        else $error("read strobe pin wrong");
      io_enable_a: assert property (
        r == 4'ha |-> aux_pin_oe_out[i] == $past(gpio_oe_in[i]))
        else $error("io enable wrong");
    end
  end
endmodule
`default_nettype wire

// >>> sim/configurable_aux_pin_selector_tb.sv
// self-checking bench for the auxiliary pin selector
`timescale 1ns/1ns
`default_nettype none
`include "aps_defines.svh"
module configurable_aux_pin_selector_tb;
  typedef struct {int due; int sel; logic [19:0] v;
    logic [19:0] m;} aps_note_s;
  localparam int HOLD = 8;
  logic clk_in = 1'b0, rst_in = 1'b1, cfg_wr = 1'b0, pd = 1'b0;
  logic busy = 1'b0, conf = 1'b0, susp = 1'b0, txa = 1'b0, rxa = 1'b0;
  logic wr_n = 1'b1, rd_n = 1'b1, pd_o;
  logic [3:0] drv = 4'h0, oe = 4'h0, ext = 4'h0, ext_en = 4'h0;
  logic [3:0] lvl, samp;
  logic [4:0] pin, pin_oe;
  logic [19:0] roles = 20'h0_0000, held, roles_o;
  logic [19:0] cw [4] = '{20'h0_a510, 20'h6_2acb, 20'hb_1096, 20'h9_8743};
  logic [19:0] ce [4] = '{20'h0_a510, 20'h6_2acb, 20'hf_1096, 20'h9_8743};
  logic [3:0] pw = 4'b0110, pe = 4'b0111;
  string names [5] = '{"pins", "enables", "roles", "pulldown", "sample"};
  aps_note_s q[$];
  aps_note_s n;
  logic [19:0] seen [5];
  int cyc = 0, fails = 0, comparisons = 0;
  integer seed = 32'h9fa3_b1ce;

  aps_pin_selector #(.LED_HOLD_CYC(HOLD)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr),
    .cfg_roles_in(roles), .cfg_pulldown_in(pd), .usb_configured_in(conf),
    .usb_suspend_in(susp), .usb_tx_act_in(txa), .usb_rx_act_in(rxa),
    .uart_tx_busy_in(busy), .gpio_drive_in(drv), .gpio_oe_in(oe),
    .parallel_write_strobe_n_in(wr_n), .parallel_read_strobe_n_in(rd_n),
    .gpio_sample_out(samp), .aux_pin_in(lvl), .aux_pin_out(pin),
    .aux_pin_oe_out(pin_oe), .cfg_roles_out(roles_o),
    .soft_pulldown_en_out(pd_o));
  aps_far_side far (.pin_in(pin[3:0]), .pin_oe_in(pin_oe[3:0]),
    .ext_in(ext), .ext_en_in(ext_en), .level_out(lvl));

  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;

  // --------
  // checking: notes are due at a cycle and judged mid-cycle
  // --------
  task automatic check(input string what, input logic [19:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  always @(negedge clk_in) begin
    seen = '{{15'h0, pin}, {15'h0, pin_oe}, roles_o, {19'h0, pd_o},
      {16'h0, samp}};
    while (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      check(names[n.sel], seen[n.sel] & n.m, n.v & n.m);
    end
  end
  task automatic note(input int sel, input logic [19:0] v, m, input int d);
    q.push_back('{cyc + d, sel, v, m});
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // --------
  // stimulus
  // --------
  task automatic step;
    @(posedge clk_in);
    #2;
  endtask
  // {care, level, enable} for one pin; led and clock levels are not judged
  function automatic logic [2:0] want(input logic [3:0] c, input int i);
    case (c)
      4'h0: return {1'b1, ~busy, 1'b1};
      4'h1: return {1'b1, ~(conf & ~susp), 1'b1};
      4'h5: return {1'b1, ~susp, 1'b1};
      4'ha: return {oe[i], drv[i], oe[i]};
      4'hb: return {1'b1, wr_n, 1'b1};
      4'hc: return {1'b1, rd_n, 1'b1};
      4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9: return 3'b001;
      default: return 3'b111;
    endcase
  endfunction
  task automatic run(input int k);
    logic [19:0] v = 20'h0_0000, m = 20'h0_0000, e = 20'h0_0000;
    logic [19:0] ps = 20'h0_0000, pm = 20'h0_0000;
    logic [31:0] r;
    for (int j = 0; j < k; j++) begin
      r = $random(seed);
      {busy, conf, susp, txa, rxa, wr_n, rd_n, drv, oe, ext, ext_en} = r[22:0];
      // suspend kept rarer so the divided clocks get to run
      susp = susp & r[31];
      // pin levels this cycle: last cycle's drive, this cycle's far side
      for (int i = 0; i < 4; i++) begin
        ps[i] = e[i] ? v[i] : (ext_en[i] ? ext[i] : 1'b1);
        pm[i] = (m[i] | ~e[i]) & (j > 0);
      end
      note(4, ps, pm, 1);
      for (int i = 0; i < 5; i++)
        {m[i], v[i], e[i]} = want(held[4*i +: 4], i);
      note(0, v, m, 1);
      note(1, e, 20'h0_001f, 1);
      step;
    end
  endtask

  initial begin
    repeat (11) @(posedge clk_in);
    #2;
    note(0, 20'h0_001f, 20'h0_001f, 0);
    note(1, 20'h0_001f, 20'h0_001f, 0);
    note(2, `APS_CFG_RESET, 20'hf_ffff, 0);
    note(3, 20'h0_0000, 20'h0_0001, 0);
    note(4, 20'h0_0000, 20'h0_000f, 0);
    step;
    rst_in = 1'b0;
    held = `APS_CFG_RESET;
    run(6);
    for (int t = 0; t < 4; t++) begin
      cfg_wr = 1'b1;
      roles = cw[t];
      pd = pw[t];
      note(2, ce[t], 20'hf_ffff, 1);
      note(3, {19'h0, pe[t]}, 20'h0_0001, 1);
      step;
      cfg_wr = 1'b0;
      held = ce[t];
      run(30);
    end
    // one short receive burst must stay visible for the hold time
    {txa, rxa, susp} = 3'b000;
    repeat (HOLD + 4) step;
    note(0, 20'h0_0003, 20'h0_0003, 0);
    rxa = 1'b1;
    note(0, 20'h0_0000, 20'h0_0003, 3);
    note(0, 20'h0_0000, 20'h0_0003, HOLD);
    note(0, 20'h0_0003, 20'h0_0003, HOLD + 6);
    step;
    rxa = 1'b0;
    repeat (HOLD + 6) step;
    print_verdict;
  end
  // about three and a half times the expected run length
  initial begin
    #(40 * 600);
    fails++;
    print_verdict;
  end
endmodule

bind aps_pin_selector aps_pin_monitor mon (
  .clk_in(clk_in), .rst_in(rst_in), .usb_configured_in(usb_configured_in),
  .usb_suspend_in(usb_suspend_in), .usb_tx_act_in(usb_tx_act_in),
  .uart_tx_busy_in(uart_tx_busy_in), .gpio_oe_in(gpio_oe_in),
  .parallel_write_strobe_n_in(parallel_write_strobe_n_in),
  .parallel_read_strobe_n_in(parallel_read_strobe_n_in),
  .aux_pin_out(aux_pin_out), .aux_pin_oe_out(aux_pin_oe_out),
  .cfg_roles_out(cfg_roles_out));
`default_nettype wire
